// *** shared/angle_spi_pkg.sv ***
package angle_spi_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int NUM_REGS = 32;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [4:0] REG_FIELD_FLAGS = 5'h1B;
  localparam logic [4:0] REG_DIRECTION = 5'h09;
  localparam int FIELD_HIGH_BIT = 7;
  localparam int FIELD_LOW_BIT = 6;
  localparam int DIRECTION_BIT = 7;
  localparam int ANGLE_BITS = 12;
  localparam int CLK_MHZ = 125;
  localparam int REFRESH_US = 1;
  localparam int REFRESH_CYCLES = REFRESH_US * CLK_MHZ;
  localparam int NVM_MS = 20;
  localparam int NVM_CYCLES = NVM_MS * 1000 * CLK_MHZ;
  localparam int IDLE_ANGLE_NS = 150;
  localparam int IDLE_REG_NS = 750;
  localparam int CLK_NS = 8;
  localparam int IDLE_ANGLE_CYCLES = (IDLE_ANGLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IDLE_REG_CYCLES = (IDLE_REG_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_MIN_NS = 40;
  localparam int SCLK_HALF_CYCLES = (SCLK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [2:0] {
    RESP_ANGLE = 3'b001,
    RESP_READ = 3'b010,
    RESP_WRITE = 3'b100
  } resp_kind_t;
endpackage : angle_spi_pkg

// *** shared/angle_spi_if.sv ***
`timescale 1ns/1ps
interface angle_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b0;
  modport sensor (input cs_n, input sclk, input mosi, output miso_o, output miso_oe);
  modport master (output cs_n, output sclk, output mosi, input miso);
endinterface : angle_spi_if

// *** logic/angle_sensor_spi_slave.sv ***
`timescale 1ns/1ps
module angle_sensor_spi_slave
  import angle_spi_pkg::*;
#(
  parameter int NVM_WAIT = NVM_CYCLES,
  parameter int REFRESH = REFRESH_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  angle_spi_if.sensor spi,
  input wire logic [15:0] angle_i,
  input wire logic field_high_flag_i,
  input wire logic field_low_flag_i,
  output logic direction_ccw_o,
  output logic write_busy_o
);
  logic [2:0] cs_s_q, sclk_s_q;
  logic [1:0] mosi_s_q;
  logic mode_idle_q;
  logic [15:0] buf_q, shift_q, rx_q;
  logic [4:0] cnt_q;
  logic [31:0] ref_q, nvm_q;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] pend_val_q;
  logic [4:0] pend_addr_q, resp_addr_q;
  resp_kind_t kind_q;
  logic miso_q, oe_q;
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  logic [7:0] resp_byte;

  function automatic logic [7:0] reg_view(input logic [4:0] a, input logic [7:0] v, input logic h, input logic l);
    reg_view = v;
    if (a == REG_FIELD_FLAGS) begin
      reg_view = 8'h00;
      reg_view[FIELD_HIGH_BIT] = h;
      reg_view[FIELD_LOW_BIT] = l;
    end
  endfunction : reg_view

  assign resp_byte = reg_view(resp_addr_q, regs_q[resp_addr_q], field_high_flag_i, field_low_flag_i);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_s_q <= 3'h7;
      sclk_s_q <= 3'h0;
      mosi_s_q <= 2'h0;
    end else begin
      cs_s_q <= {cs_s_q[1:0], spi.cs_n};
      sclk_s_q <= {sclk_s_q[1:0], spi.sclk};
      mosi_s_q <= {mosi_s_q[0], spi.mosi};
    end
  end

  assign cs_fall = cs_s_q[2] && !cs_s_q[1];
  assign cs_rise = !cs_s_q[2] && cs_s_q[1];
  assign sck_rise = !sclk_s_q[2] && sclk_s_q[1] && !cs_s_q[1];
  assign sck_fall = sclk_s_q[2] && !sclk_s_q[1] && !cs_s_q[1];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_idle_q <= 1'b0;
    end else if (cs_fall) begin
      mode_idle_q <= sclk_s_q[1];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 32'h0;
      buf_q <= 16'h0000;
    end else if (ref_q >= 32'(REFRESH - 1)) begin
      ref_q <= 32'h0;
      if (cs_s_q[1] && cs_s_q[2]) begin
        buf_q <= {angle_i[15:16-ANGLE_BITS], {(16-ANGLE_BITS){1'b0}}};
      end
    end else begin
      ref_q <= ref_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 5'h0;
      rx_q <= 16'h0000;
    end else if (cs_s_q[1]) begin
      cnt_q <= 5'h0;
    end else if (sck_rise) begin
      rx_q <= {rx_q[14:0], mosi_s_q[1]};
      cnt_q <= (cnt_q == 5'h10) ? cnt_q : cnt_q + 5'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kind_q <= RESP_ANGLE;
      resp_addr_q <= 5'h00;
    end else if (cs_rise) begin
      kind_q <= RESP_ANGLE;
      if (cnt_q == 5'h10) begin
        resp_addr_q <= rx_q[12:8];
        case (rx_q[15:13])
          CMD_READ: kind_q <= RESP_READ;
          CMD_WRITE: kind_q <= RESP_WRITE;
          default: kind_q <= RESP_ANGLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nvm_q <= 32'h0;
      pend_val_q <= 8'h00;
      pend_addr_q <= 5'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (cs_rise && cnt_q == 5'h10 && rx_q[15:13] == CMD_WRITE && nvm_q == 32'h0) begin
      pend_addr_q <= rx_q[12:8];
      pend_val_q <= rx_q[7:0];
      nvm_q <= 32'(NVM_WAIT);
    end else if (nvm_q == 32'h1) begin
      regs_q[pend_addr_q] <= pend_val_q;
      nvm_q <= 32'h0;
    end else if (nvm_q != 32'h0) begin
      nvm_q <= nvm_q - 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_q <= 16'h0000;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (cs_fall) begin
      oe_q <= 1'b1;
      if (kind_q == RESP_ANGLE) begin
        shift_q <= {buf_q[14:0], 1'b0};
        miso_q <= buf_q[15];
      end else begin
        shift_q <= {resp_byte[6:0], 9'h000};
        miso_q <= resp_byte[7];
      end
    end else if (cs_s_q[1]) begin
      oe_q <= 1'b0;
      miso_q <= 1'b0;
    end else if (sck_fall && !(mode_idle_q && cnt_q == 5'h0)) begin
      miso_q <= shift_q[15];
      shift_q <= {shift_q[14:0], 1'b0};
    end
  end

  assign spi.miso_o = miso_q;
  assign spi.miso_oe = oe_q;
  assign direction_ccw_o = regs_q[REG_DIRECTION][DIRECTION_BIT];
  assign write_busy_o = (nvm_q != 32'h0);
endmodule : angle_sensor_spi_slave

// *** logic/angle_spi_master.sv ***
`timescale 1ns/1ps
module angle_spi_master
  import angle_spi_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  angle_spi_if.master spi,
  input wire logic start_i,
  input wire logic [15:0] cmd_i,
  input wire logic [4:0] nbits_i,
  input wire logic mode3_i,
  output logic ready_o,
  output logic done_o,
  output logic [15:0] rdata_o
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETUP = 4'b0010,
    S_SHIFT = 4'b0100,
    S_GAP = 4'b1000
  } mst_state_t;
  mst_state_t st_q;
  logic [15:0] tx_q, rx_q;
  logic [4:0] left_q;
  logic [7:0] div_q;
  logic [31:0] gap_q;
  logic sclk_q, cs_n_q, mode_q, done_q, phase_q, was_write_q;
  logic [1:0] miso_s_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      miso_s_q <= 2'h0;
    end else begin
      miso_s_q <= {miso_s_q[0], spi.miso};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= S_IDLE;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      left_q <= 5'h0;
      div_q <= 8'h0;
      gap_q <= 32'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mode_q <= 1'b0;
      done_q <= 1'b0;
      phase_q <= 1'b0;
      was_write_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start_i) begin
            tx_q <= cmd_i;
            rx_q <= 16'h0000;
            left_q <= (nbits_i == 5'h0 || nbits_i > 5'h10) ? 5'h10 : nbits_i;
            mode_q <= mode3_i;
            sclk_q <= mode3_i;
            was_write_q <= (cmd_i[15:13] == CMD_WRITE);
            div_q <= 8'(4 * SCLK_HALF_CYCLES);
            st_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          cs_n_q <= 1'b0;
          if (div_q == 8'h0) begin
            div_q <= 8'(4 * SCLK_HALF_CYCLES);
            sclk_q <= 1'b0;
            phase_q <= 1'b0;
            st_q <= S_SHIFT;
          end else begin
            div_q <= div_q - 8'h1;
          end
        end
        S_SHIFT: begin
          if (div_q == 8'h0) begin
            div_q <= 8'(4 * SCLK_HALF_CYCLES);
            if (!phase_q) begin
              sclk_q <= 1'b1;
              rx_q <= {rx_q[14:0], miso_s_q[1]};
              phase_q <= 1'b1;
            end else if (left_q == 5'h1) begin
              cs_n_q <= 1'b1;
              sclk_q <= mode_q;
              done_q <= 1'b1;
              gap_q <= was_write_q ? 32'(NVM_CYCLES) : 32'(IDLE_REG_CYCLES + 4);
              st_q <= S_GAP;
            end else begin
              sclk_q <= 1'b0;
              tx_q <= {tx_q[14:0], 1'b0};
              left_q <= left_q - 5'h1;
              phase_q <= 1'b0;
            end
          end else begin
            div_q <= div_q - 8'h1;
          end
        end
        S_GAP: begin
          if (gap_q == 32'h0) begin
            st_q <= S_IDLE;
          end else begin
            gap_q <= gap_q - 32'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign spi.cs_n = cs_n_q;
  assign spi.sclk = sclk_q;
  assign spi.mosi = tx_q[15] && !cs_n_q;
  assign ready_o = (st_q == S_IDLE);
  assign done_o = done_q;
  assign rdata_o = rx_q;
endmodule : angle_spi_master

// *** bench/angle_sensor_spi_slave_asserts.sv ***
`timescale 1ns/1ps
module angle_sensor_spi_slave_asserts
  import angle_spi_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic sclk_q;
  logic [4:0] rise_q;
  logic [7:0] idle_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Clock rises per frame, idle time
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
      rise_q <= 5'h00;
      idle_q <= 8'h00;
    end else begin
      sclk_q <= sclk;
      rise_q <= cs_n ? 5'h00 : rise_q + 5'((sclk && !sclk_q) ? 1 : 0);
      idle_q <= !cs_n ? 8'h00 : (idle_q == 8'hFF ? idle_q : idle_q + 8'h01);
    end
  end
  sequence s_start;
    $fell(cs_n);
  endsequence
  a_cs_setup: assert property (s_start |=> $stable(sclk)[*8]) else $error("clock moved after select");
  a_oe_on: assert property (s_start |-> ##[1:4] miso_oe) else $error("output not driven");
  a_oe_release: assert property (cs_n[*4] |-> !miso_oe) else $error("output not released");
  a_sclk_high: assert property ($rose(sclk) |=> sclk[*2]) else $error("clock high too short");
  a_sclk_low: assert property ($fell(sclk) && !cs_n |=> !sclk[*2]) else $error("clock low too short");
  a_miso_edge: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk)
    else $error("output changed while clock high");
  a_cs_hold: assert property (!cs_n && $rose(sclk) |=> !cs_n[*4]) else $error("select rose too soon");
  a_bit_limit: assert property (!cs_n |-> rise_q <= 5'h10) else $error("frame too long");
  a_zero_tail: assert property (!cs_n && sclk && !sclk_q && rise_q >= 5'h0C |-> !miso)
    else $error("tail bit not zero");
  a_idle_gap: assert property (s_start |-> idle_q >= IDLE_REG_CYCLES) else $error("idle gap short");
  a_mosi_idle: assert property (cs_n |-> !mosi) else $error("data driven while deselected");
endmodule : angle_sensor_spi_slave_asserts

// *** bench/angle_sensor_spi_slave_tb.sv ***
`timescale 1ns/1ps
module angle_sensor_spi_slave_tb;
  import angle_spi_pkg::*;
  logic clk_i, arst_n_i, m_arst_n, fh, fl, ccw, busy, start, m3, rdy, done;
  logic [15:0] ang, cmd, rdata, rd;
  logic [4:0] nb;
  int n_fail, compares;
  angle_spi_if spi_bus ();
  angle_sensor_spi_slave #(.NVM_WAIT(400), .REFRESH(REFRESH_CYCLES)) angle_sensor_spi_slave_i (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .spi(spi_bus), .angle_i(ang), .field_high_flag_i(fh), .field_low_flag_i(fl),
    .direction_ccw_o(ccw), .write_busy_o(busy));
  angle_spi_master angle_spi_master_i (.clk_i(clk_i), .arst_n_i(m_arst_n), .spi(spi_bus), .start_i(start),
    .cmd_i(cmd), .nbits_i(nb), .mode3_i(m3), .ready_o(rdy), .done_o(done), .rdata_o(rdata));
  angle_sensor_spi_slave_asserts chk_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n(spi_bus.cs_n),
    .sclk(spi_bus.sclk), .mosi(spi_bus.mosi), .miso_o(spi_bus.miso_o), .miso_oe(spi_bus.miso_oe),
    .miso(spi_bus.miso));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic until_low(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b0 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k == 5000) n_fail++;
  endtask : until_low
  task automatic frame(input logic [15:0] c, input logic [4:0] n, input logic mode, output logic [15:0] d);
    int k;
    if (m3 !== mode) begin
      m3 = mode;
      tick(20);
    end
    k = 0;
    while (rdy !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k == 5000) n_fail++;
    cmd = c;
    nb = n;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      tick(1);
      k++;
    end
    if (k == 5000) n_fail++;
    d = rdata;
  endtask : frame
  task automatic mrst();
    tick(IDLE_REG_CYCLES);
    m_arst_n = 1'b0;
    tick(1);
    m_arst_n = 1'b1;
  endtask : mrst
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    tick(60000);
    n_fail++;
    wrap_up();
  end
  initial begin
    {arst_n_i, m_arst_n, fh, fl, start, m3, cmd, nb, n_fail, compares} = '0;
    ang = 16'hABCD;
    tick(2);
    {arst_n_i, m_arst_n} = 2'h3;
    tick(2 * REFRESH_CYCLES);
    frame(16'h0000, 5'h10, 1'b0, rd); check(rd, 16'hABC0);
    frame(16'h0000, 5'h10, 1'b1, rd); check(rd, 16'hABC0);
    frame(16'h0000, 5'h0C, 1'b1, rd); check(rd, 16'h0ABC);
    frame(16'h0000, 5'h08, 1'b0, rd); check(rd, 16'h00AB);
    fork
      frame(16'h0000, 5'h10, 1'b0, rd);
      begin
        @(negedge spi_bus.cs_n);
        tick(20);
        ang = 16'h1234;
      end
    join
    check(rd, 16'hABC0);
    tick(2 * REFRESH_CYCLES);
    frame(16'h0000, 5'h10, 1'b0, rd); check(rd, 16'h1230);
    for (int i = 0; i < 4; i++) begin
      {fh, fl} = 2'(i);
      frame({CMD_READ, REG_FIELD_FLAGS, 8'h00}, 5'h10, i[0], rd); check(rd, 16'h1230);
      frame(16'h0000, 5'h10, 1'b0, rd); check(rd, {2'(i), 14'h0000});
    end
    frame({CMD_WRITE, REG_DIRECTION, 8'h80}, 5'h10, 1'b0, rd);
    tick(5);
    check({15'h0000, busy}, 16'h0001);
    mrst();
    until_low(busy);
    frame(16'h0000, 5'h10, 1'b0, rd); check(rd, 16'h8000);
    check({15'h0000, ccw}, 16'h0001);
    frame({CMD_WRITE, REG_DIRECTION, 8'h00}, 5'h10, 1'b1, rd);
    mrst();
    frame(16'h0000, 5'h10, 1'b0, rd); check(rd, 16'h8000);
    until_low(busy);
    frame({CMD_READ, REG_DIRECTION, 8'h00}, 5'h10, 1'b0, rd);
    frame(16'h0000, 5'h10, 1'b0, rd); check(rd, 16'h0000);
    check({15'h0000, ccw}, 16'h0000);
    wrap_up();
  end
endmodule : angle_sensor_spi_slave_tb
